/* rtl/sll_status_bank.sv */
// lane link status registers with error counters and axi4-lite slave
`timescale 1ns/1ps
module sll_status_bank
  import sll_pkg::*;
#(
  parameter int AW = 16
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  // lane receiver side
  input  wire sll_err_t [NLANE-1:0]  lane_err_i,
  input  wire sll_sync_t [NLANE-1:0] lane_sync_i,
  input  wire sll_cfg_t [NLANE-1:0]  lane_cfg_i,
  output logic                       skip_alignment_sequence_o,
  // axi4-lite write address
  input  wire logic [AW-1:0]         s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [AW-1:0]         s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // interrupt
  output logic                       irq_o
);

  // index field must reach bit 13; a narrower bus cannot decode the map
  if (AW < 14) begin : g_aw_check
    $error("AW too small for register map");
  end
  // every interrupt bit must fit one data word
  if (IRQ_W > 32) begin : g_irq_check
    $error("too many interrupt bits for one word");
  end

  // lane state
  logic [7:0]        cnt_ff     [NLANE][NCLASS];
  logic [7:0]        nxt_cnt    [NLANE][NCLASS];
  logic [7:0]        stat_ff    [NLANE];
  logic [7:0]        nxt_stat   [NLANE];
  logic [7:0]        sum_ff     [NLANE];
  logic [7:0]        nxt_sum    [NLANE];
  logic [NLANE-1:0]  sum_ok_ff;
  logic [NLANE-1:0]  nxt_sum_ok;
  // control state
  logic [7:0]        error_count_limit_ff;
  logic [7:0]        nxt_limit;
  logic              skip_ff;
  logic              nxt_skip;
  logic [IRQ_W-1:0]  irq_st_ff;
  logic [IRQ_W-1:0]  nxt_irq_st;
  logic [IRQ_W-1:0]  irq_msk_ff;
  logic [IRQ_W-1:0]  nxt_irq_msk;
  logic [NLANE-1:0]  cnt_clr;
  // write channel state
  logic              aw_hold_ff;
  logic              nxt_aw_hold;
  logic [11:0]       aw_idx_ff;
  logic [11:0]       nxt_aw_idx;
  logic              w_hold_ff;
  logic              nxt_w_hold;
  logic [31:0]       wdata_ff;
  logic [31:0]       nxt_wdata;
  logic [3:0]        wstrb_ff;
  logic [3:0]        nxt_wstrb;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              wr_go;
  // read channel state
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  logic [11:0]       ar_idx;

  // handshake readies are combinational; one write and one read in flight
  assign s_axi_awready_o = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready_o  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign skip_alignment_sequence_o = skip_ff;
  // level interrupt: any status bit the mask lets through
  assign irq_o = |(irq_st_ff & irq_msk_ff);
  // a write lands once both halves are held and no answer is pending
  assign wr_go  = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  // address bits 1:0 are ignored; registers are whole words
  assign ar_idx = s_axi_araddr_i[13:2];

  // write channel: address and data taken in either order
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_idx  = s_axi_awaddr_i[13:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata_i;
      nxt_wstrb  = s_axi_wstrb_i;
    end
    if (wr_go) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      // status offsets answer OKAY so a stray write never stalls software
      case (aw_idx_ff)
        IDX_LANE5, IDX_LANE6, IDX_LANE7,
        IDX_CTRL, IDX_IRQ_ST, IDX_IRQ_MSK, IDX_CNT_CLR: begin
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end else if (bvalid_ff && s_axi_bready_i) begin
      // answer stands until the master takes it
      nxt_bvalid = 1'b0;
    end
  end

  // write channel registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_hold_ff <= 1'b0;
      aw_idx_ff  <= 12'h000;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_idx_ff  <= nxt_aw_idx;
      w_hold_ff  <= nxt_w_hold;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // read channel: data one cycle after the address is taken
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      // unmapped indices answer SLVERR and read as zero
      case (ar_idx)
        IDX_LANE5:   nxt_rdata[7:0] = stat_ff[0];
        IDX_LANE6:   nxt_rdata[7:0] = stat_ff[1];
        IDX_LANE7:   nxt_rdata[7:0] = stat_ff[2];
        IDX_CTRL: begin
          nxt_rdata[CTRL_LIMIT_LSB +: 8] = error_count_limit_ff;
          nxt_rdata[CTRL_SKIP_BIT]       = skip_ff;
        end
        IDX_IRQ_ST:  nxt_rdata[IRQ_W-1:0] = irq_st_ff;
        IDX_IRQ_MSK: nxt_rdata[IRQ_W-1:0] = irq_msk_ff;
        IDX_CNT_CLR: nxt_rdata = 32'h0000_0000; // self-clearing
        default:     nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // read answer registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // control registers; lane status offsets accept writes but keep nothing
  always_comb begin
    nxt_limit   = error_count_limit_ff;
    nxt_skip    = skip_ff;
    nxt_irq_msk = irq_msk_ff;
    cnt_clr     = '0;
    if (wr_go) begin
      case (aw_idx_ff)
        IDX_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_limit = wdata_ff[CTRL_LIMIT_LSB +: 8];
          end
          if (wstrb_ff[1]) begin
            nxt_skip = wdata_ff[CTRL_SKIP_BIT];
          end
        end
        IDX_IRQ_MSK: begin
          if (wstrb_ff[0]) begin
            nxt_irq_msk = wdata_ff[IRQ_W-1:0];
          end
        end
        IDX_CNT_CLR: begin
          if (wstrb_ff[0]) begin
            cnt_clr = wdata_ff[NLANE-1:0];
          end
        end
        default: begin
          cnt_clr = '0; // status writes dropped
        end
      endcase
    end
  end

  // lane counters, compare, checksum and status flags
  always_comb begin
    logic [IRQ_W-1:0] set_ev;
    logic [IRQ_W-1:0] clr_ev;
    logic [NCLASS-1:0] ev;
    logic [NCLASS-1:0] over;
    set_ev = '0;
    clr_ev = '0;
    ev     = '0;
    over   = '0;
    for (int l = 0; l < NLANE; l++) begin
      ev = {lane_err_i[l].disp_err, lane_err_i[l].bad_code, lane_err_i[l].stray_ctrl};
      // counters saturate so a flag cannot drop by wrapping
      for (int c = 0; c < NCLASS; c++) begin
        nxt_cnt[l][c] = cnt_ff[l][c];
        if (cnt_clr[l]) begin
          nxt_cnt[l][c] = 8'h00;
        end else if (ev[NCLASS-1-c] && cnt_ff[l][c] != CNT_MAX) begin
          nxt_cnt[l][c] = cnt_ff[l][c] + 8'h01;
        end
        over[NCLASS-1-c] = (cnt_ff[l][c] >= error_count_limit_ff);
      end
      // running byte sum; last byte carries the transmitted checksum
      nxt_sum[l]    = sum_ff[l];
      nxt_sum_ok[l] = sum_ok_ff[l];
      if (lane_cfg_i[l].valid) begin
        if (lane_cfg_i[l].last) begin
          nxt_sum_ok[l] = (lane_cfg_i[l].data == sum_ff[l]);
          nxt_sum[l]    = 8'h00;
        end else begin
          nxt_sum[l] = sum_ff[l] + lane_cfg_i[l].data;
        end
      end
      // flags trail the counters by one cycle; the compare sees registered counts
      nxt_stat[l]             = LANE_RST;
      nxt_stat[l][BIT_DISP]   = over[2];
      nxt_stat[l][BIT_BADC]   = over[1];
      nxt_stat[l][BIT_STRAY]  = over[0];
      nxt_stat[l][BIT_DESKEW] = lane_sync_i[l].deskew_ok;
      nxt_stat[l][BIT_ISYNC]  = lane_sync_i[l].initial_sync_ok;
      nxt_stat[l][BIT_SUM]    = sum_ok_ff[l];
      nxt_stat[l][BIT_FRAME]  = lane_sync_i[l].frame_lock;
      nxt_stat[l][BIT_SYMBOL] = lane_sync_i[l].symbol_lock;
      // events: a lane's error flags going from none set to some set, symbol lock falling
      set_ev[2*l]   = |nxt_stat[l][BIT_DISP:BIT_STRAY] & ~|stat_ff[l][BIT_DISP:BIT_STRAY];
      set_ev[2*l+1] = stat_ff[l][BIT_SYMBOL] & ~nxt_stat[l][BIT_SYMBOL];
    end
    // write-one-to-clear of the interrupt status
    if (wr_go && aw_idx_ff == IDX_IRQ_ST && wstrb_ff[0]) begin
      clr_ev = wdata_ff[IRQ_W-1:0];
    end
    // set wins over a same-cycle write-one-to-clear
    nxt_irq_st = (irq_st_ff & ~clr_ev) | set_ev;
  end

  // all lane flags start at zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int l = 0; l < NLANE; l++) begin
        for (int c = 0; c < NCLASS; c++) begin
          cnt_ff[l][c] <= 8'h00;
        end
        stat_ff[l] <= LANE_RST;
        sum_ff[l]  <= 8'h00;
      end
      sum_ok_ff            <= '0;
      // limit starts at the top so an error flag shows only once its counter saturates
      error_count_limit_ff <= LIMIT_RST;
      skip_ff              <= SKIP_RST;
      irq_st_ff            <= IRQ_RST;
      irq_msk_ff           <= IRQ_RST;
    end else begin
      for (int l = 0; l < NLANE; l++) begin
        for (int c = 0; c < NCLASS; c++) begin
          cnt_ff[l][c] <= nxt_cnt[l][c];
        end
        stat_ff[l] <= nxt_stat[l];
        sum_ff[l]  <= nxt_sum[l];
      end
      sum_ok_ff            <= nxt_sum_ok;
      error_count_limit_ff <= nxt_limit;
      skip_ff              <= nxt_skip;
      irq_st_ff            <= nxt_irq_st;
      irq_msk_ff           <= nxt_irq_msk;
    end
  end

endmodule

/* rtl/sll_pkg.sv */
// shared constants and types for the serial lane link status bank
package sll_pkg;
  // lanes covered by this bank, lowest first
  localparam int NLANE      = 3;
  localparam int FIRST_LANE = 5;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LANE5   = 12'h4B5;
  localparam logic [11:0] IDX_LANE6   = 12'h4B6;
  localparam logic [11:0] IDX_LANE7   = 12'h4B7;
  localparam logic [11:0] IDX_CTRL    = 12'h4C0;
  localparam logic [11:0] IDX_IRQ_ST  = 12'h4C1;
  localparam logic [11:0] IDX_IRQ_MSK = 12'h4C2;
  localparam logic [11:0] IDX_CNT_CLR = 12'h4C3;
  // lane status bit positions
  localparam int BIT_DISP   = 7;
  localparam int BIT_BADC   = 6;
  localparam int BIT_STRAY  = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ISYNC  = 3;
  localparam int BIT_SUM    = 2;
  localparam int BIT_FRAME  = 1;
  localparam int BIT_SYMBOL = 0;
  localparam logic [7:0] LANE_RST = 8'h00;
  // control register: limit in [7:0], skip flag in bit 8
  localparam int         CTRL_LIMIT_LSB = 0;
  localparam int         CTRL_SKIP_BIT  = 8;
  localparam logic [7:0] LIMIT_RST      = 8'hFF;
  localparam logic       SKIP_RST       = 1'b0;
  // interrupt bits: per lane, 2*k = errors crossed limit, 2*k+1 = symbol lock lost
  localparam int              IRQ_W   = 2 * NLANE;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
  // error classes
  localparam int NCLASS = 3;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-lane error pulses from the lane decoder
  typedef struct packed {
    logic disp_err;
    logic bad_code;
    logic stray_ctrl;
  } sll_err_t;

  // per-lane sync levels from the lane receiver
  typedef struct packed {
    logic deskew_ok;
    logic initial_sync_ok;
    logic frame_lock;
    logic symbol_lock;
  } sll_sync_t;

  // link configuration byte stream, last byte is the sent checksum
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } sll_cfg_t;
endpackage

/* dv/sll_status_bank_assertions.sv */
// bus and lane register checks on the status bank ports
`timescale 1ns/1ps
module sll_status_bank_chk
  import sll_pkg::*;
#(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic          ref_clk_i,
  input wire logic          nrst_i,
  // axi4-lite
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic          s_axi_awvalid_i,
  input wire logic          s_axi_awready_o,
  input wire logic          s_axi_wvalid_i,
  input wire logic          s_axi_wready_o,
  input wire logic [1:0]    s_axi_bresp_o,
  input wire logic          s_axi_bvalid_o,
  input wire logic          s_axi_bready_i,
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic          s_axi_arvalid_i,
  input wire logic          s_axi_arready_o,
  input wire logic [31:0]   s_axi_rdata_o,
  input wire logic [1:0]    s_axi_rresp_o,
  input wire logic          s_axi_rvalid_o,
  input wire logic          s_axi_rready_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [11:0] ridx_ff, nxt_ridx, widx_ff, nxt_widx;
  logic        lane_r, lane_w, bad_r;
  // remember the index of the request in flight
  always_comb begin
    nxt_ridx = (s_axi_arvalid_i && s_axi_arready_o) ? s_axi_araddr_i[13:2] : ridx_ff;
    nxt_widx = (s_axi_awvalid_i && s_axi_awready_o) ? s_axi_awaddr_i[13:2] : widx_ff;
    lane_r   = ridx_ff >= IDX_LANE5 && ridx_ff <= IDX_LANE7;
    lane_w   = widx_ff >= IDX_LANE5 && widx_ff <= IDX_LANE7;
    bad_r    = !lane_r && !(ridx_ff >= IDX_CTRL && ridx_ff <= IDX_CNT_CLR);
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ridx_ff <= 12'h000;
      widx_ff <= 12'h000;
    end else begin
      ridx_ff <= nxt_ridx;
      widx_ff <= nxt_widx;
    end
  end
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer not released");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer not released");
  aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  lane_read_a: assert property (s_axi_rvalid_o && lane_r |->
    s_axi_rresp_o == RESP_OKAY && s_axi_rdata_o[31:8] == 24'h0)
    else $error("lane status read malformed");
  bad_read_a: assert property (s_axi_rvalid_o && bad_r |-> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  lane_write_a: assert property (s_axi_bvalid_o && lane_w |-> s_axi_bresp_o == RESP_OKAY)
    else $error("lane status write refused");
endmodule
bind sll_status_bank sll_status_bank_chk #(.AW(AW)) u_chk (
  .ref_clk_i       (ref_clk_i),
  .nrst_i          (nrst_i),
  .s_axi_awaddr_i  (s_axi_awaddr_i),
  .s_axi_awvalid_i (s_axi_awvalid_i),
  .s_axi_awready_o (s_axi_awready_o),
  .s_axi_wvalid_i  (s_axi_wvalid_i),
  .s_axi_wready_o  (s_axi_wready_o),
  .s_axi_bresp_o   (s_axi_bresp_o),
  .s_axi_bvalid_o  (s_axi_bvalid_o),
  .s_axi_bready_i  (s_axi_bready_i),
  .s_axi_araddr_i  (s_axi_araddr_i),
  .s_axi_arvalid_i (s_axi_arvalid_i),
  .s_axi_arready_o (s_axi_arready_o),
  .s_axi_rdata_o   (s_axi_rdata_o),
  .s_axi_rresp_o   (s_axi_rresp_o),
  .s_axi_rvalid_o  (s_axi_rvalid_o),
  .s_axi_rready_i  (s_axi_rready_i)
);

/* dv/sll_tx_model.sv */
// transmitter-side model driving lane errors, sync levels and config bytes
`timescale 1ns/1ps
module sll_tx_model
  import sll_pkg::*;
(
  // clock
  input  wire logic             ref_clk_i,
  // lane streams
  output sll_err_t  [NLANE-1:0] lane_err_o,
  output sll_sync_t [NLANE-1:0] lane_sync_o,
  output sll_cfg_t  [NLANE-1:0] lane_cfg_o
);
  // quiet lanes at time zero
  initial begin
    lane_err_o  = '0;
    lane_sync_o = '0;
    lane_cfg_o  = '0;
  end
  // n back-to-back one-cycle error pulses
  task automatic errs(input int k, input sll_err_t e, input int n);
    repeat (n) begin
      lane_err_o[k] <= e;
      @(posedge ref_clk_i);
    end
    lane_err_o[k] <= '0;
    @(posedge ref_clk_i);
  endtask
  // sync levels change one lane at a time
  task automatic sync(input int k, input logic [3:0] v);
    lane_sync_o[k] <= v;
    @(posedge ref_clk_i);
  endtask
  // two config bytes then the sent checksum
  task automatic cfg(input int k, input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
    logic [7:0] q [3];
    q = '{a, b, s};
    for (int i = 0; i < 3; i++) begin
      lane_cfg_o[k] <= '{1'h1, i == 2, q[i]};
      @(posedge ref_clk_i);
    end
    // idle data inverted so a stale byte never looks valid by chance
    lane_cfg_o[k] <= '{1'h0, 1'h0, ~s};
    @(posedge ref_clk_i);
  endtask
endmodule

/* dv/sll_status_bank_tb.sv */
// self-checking bench for the lane link status bank
`timescale 1ns/1ps
module sll_status_bank_tb
  import sll_pkg::*;
;
  logic                  ref_clk_i = 1'h0;
  logic                  nrst_i = 1'h0;
  sll_err_t  [NLANE-1:0] lane_err_i;
  sll_sync_t [NLANE-1:0] lane_sync_i;
  sll_cfg_t  [NLANE-1:0] lane_cfg_i;
  logic [15:0]           s_axi_awaddr_i = 16'h0, s_axi_araddr_i = 16'h0;
  logic [31:0]           s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdat;
  logic [3:0]            s_axi_wstrb_i = 4'hF;
  logic [1:0]            s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic                  s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic                  s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic                  s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic                  irq_o, skip_alignment_sequence_o;
  int                    err_count = 0, total_checks = 0;
  sll_status_bank dut (
    .ref_clk_i                 (ref_clk_i),
    .nrst_i                    (nrst_i),
    .lane_err_i                (lane_err_i),
    .lane_sync_i               (lane_sync_i),
    .lane_cfg_i                (lane_cfg_i),
    .skip_alignment_sequence_o (skip_alignment_sequence_o),
    .s_axi_awaddr_i            (s_axi_awaddr_i),
    .s_axi_awvalid_i           (s_axi_awvalid_i),
    .s_axi_awready_o           (s_axi_awready_o),
    .s_axi_wdata_i             (s_axi_wdata_i),
    .s_axi_wstrb_i             (s_axi_wstrb_i),
    .s_axi_wvalid_i            (s_axi_wvalid_i),
    .s_axi_wready_o            (s_axi_wready_o),
    .s_axi_bresp_o             (s_axi_bresp_o),
    .s_axi_bvalid_o            (s_axi_bvalid_o),
    .s_axi_bready_i            (s_axi_bready_i),
    .s_axi_araddr_i            (s_axi_araddr_i),
    .s_axi_arvalid_i           (s_axi_arvalid_i),
    .s_axi_arready_o           (s_axi_arready_o),
    .s_axi_rdata_o             (s_axi_rdata_o),
    .s_axi_rresp_o             (s_axi_rresp_o),
    .s_axi_rvalid_o            (s_axi_rvalid_o),
    .s_axi_rready_i            (s_axi_rready_i),
    .irq_o                     (irq_o)
  );
  sll_tx_model tx (.ref_clk_i(ref_clk_i), .lane_err_o(lane_err_i), .lane_sync_o(lane_sync_i), .lane_cfg_o(lane_cfg_i));
  // 100 mhz clock
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    s_axi_awaddr_i  <= {2'h0, idx, 2'h0};
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i  <= 1'h1;
    s_axi_bready_i  <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
    end while (!(s_axi_bvalid_o && s_axi_bready_i));
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [11:0] idx);
    s_axi_araddr_i  <= {2'h0, idx, 2'h0};
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i  <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (!(s_axi_rvalid_o && s_axi_rready_i));
    rdat = s_axi_rdata_o;
    rsp  = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask
  task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rdat, exp);
    chk(rsp, RESP_OKAY);
  endtask
  task automatic t_reset();
    for (int k = 0; k < NLANE; k++) rc(IDX_LANE5 + 12'(k), 32'h0);
    rc(IDX_CTRL, 32'hFF);
    $display("test reset done");
  endtask
  // second pass runs in skip mode: symbol lock must still be reported
  task automatic t_sync();
    logic [3:0] p;
    for (int j = 0; j < 2; j++) begin
      wr(IDX_CTRL, 32'hFF | (j << 8));
      chk(skip_alignment_sequence_o, j[0]);
      for (int k = 0; k < NLANE; k++) tx.sync(k, (j == 0 ? 4'hA : 4'h5) ^ 4'(k));
      for (int k = 0; k < NLANE; k++) begin
        p = (j == 0 ? 4'hA : 4'h5) ^ 4'(k);
        rc(IDX_LANE5 + 12'(k), {27'h0, p[3:2], 1'h0, p[1:0]});
      end
    end
    for (int k = 0; k < NLANE; k++) tx.sync(k, 4'h0);
    $display("test sync done");
  endtask
  // limit 3: two errors stay below, the third reaches it
  task automatic t_err();
    // symbol lock dropped on every lane during the sync test
    rc(IDX_IRQ_ST, 32'h2A);
    wr(IDX_CTRL, 32'h3);
    wr(IDX_IRQ_ST, 32'h3F);
    for (int c = 0; c < NCLASS; c++) begin
      tx.errs(c, sll_err_t'(3'h4 >> c), 2);
      rc(IDX_LANE5 + 12'(c), 32'h0);
      tx.errs(c, sll_err_t'(3'h4 >> c), 1);
      rc(IDX_LANE5 + 12'(c), 32'h80 >> c);
    end
    rc(IDX_IRQ_ST, 32'h15);
    chk(irq_o, 1'h0);
    wr(IDX_IRQ_MSK, 32'h4);
    chk(irq_o, 1'h1);
    wr(IDX_IRQ_ST, 32'h4);
    chk(irq_o, 1'h0);
    wr(IDX_CNT_CLR, 32'h7);
    for (int k = 0; k < NLANE; k++) rc(IDX_LANE5 + 12'(k), 32'h0);
    $display("test errors done");
  endtask
  task automatic t_sum();
    tx.cfg(1, 8'h12, 8'h34, 8'h46);
    rc(IDX_LANE6, 32'h4);
    tx.cfg(1, 8'h12, 8'h34, 8'h47);
    rc(IDX_LANE6, 32'h0);
    $display("test checksum done");
  endtask
  task automatic t_ro();
    tx.cfg(2, 8'hF0, 8'h0F, 8'hFF);
    wr(IDX_LANE7, 32'hFB);
    chk(rsp, RESP_OKAY);
    rc(IDX_LANE7, 32'h4);
    rd(12'h4B8);
    chk(rsp, RESP_SLVERR);
    chk(rdat, 32'h0);
    $display("test read-only done");
  endtask
  // watchdog well beyond the roughly 165 cycles the tests need
  initial begin
    #200us;
    err_count++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    @(posedge ref_clk_i);
    t_reset();
    t_sync();
    t_err();
    t_sum();
    t_ro();
    conclude();
  end
endmodule
